/* File: hdl/pcapwm_core.sv */
// pwm cycle configuration, cycle overflow flag, auto-reload path and per-channel pwm compare
// assumes an apb3 master on MCLK_I and a one-cycle COUNT_TICK_I pulse from the timebase
`timescale 1ns/1ns
`default_nettype none

module pcapwm_core #(
    parameter int unsigned NUM_CH = 3
) (
    input  wire logic                          MCLK_I,
    input  wire logic                          RST_I,
    input  wire logic                          PSEL_I,
    input  wire logic                          PENABLE_I,
    input  wire logic                          PWRITE_I,
    input  wire logic [pcapwm_pkg::ADDR_W-1:0] PADDR_I,
    input  wire logic [pcapwm_pkg::DATA_W-1:0] PWDATA_I,
    input  wire logic                          COUNT_TICK_I,
    output logic                               PREADY_O,
    output logic                               PSLVERR_O,
    output logic      [pcapwm_pkg::DATA_W-1:0] PRDATA_O,
    output logic                               IRQ_O,
    output logic      [NUM_CH-1:0]             PWM_O
);
    import pcapwm_pkg::*;

    // mask of the low bits that form one pwm cycle
    function automatic logic [CNT_W-1:0] len_mask(input logic [CFG_LEN_W-1:0] sel);
        logic [31:0] m;
        m = (LEN_ONE << (BASE_LEN + int'(sel))) - LEN_ONE;
        return m[CNT_W-1:0];
    endfunction : len_mask

    // one register of a per-channel bank sits at the bank base plus the channel number
    function automatic logic reg_hit(input logic [IDX_W-1:0] sel, input logic [IDX_W-1:0] base,
                                     input int ch);
        return sel == (base + IDX_W'(ch));
    endfunction : reg_hit

    logic [BYTE_W-1:0]    mode [NUM_CH];
    logic [CNT_W-1:0]     cmp  [NUM_CH];
    logic [CNT_W-1:0]     rld  [NUM_CH];
    logic                 rsel;
    logic                 irq_en;
    logic                 flag;
    logic [CFG_LEN_W-1:0] len_sel;
    logic [CNT_W-1:0]     count;
    logic [NUM_CH-1:0]    pwm_q;

    wire                  setup   = PSEL_I & ~PENABLE_I;
    wire                  access  = PSEL_I & PENABLE_I;
    wire                  wr      = access & PWRITE_I;
    wire  [IDX_W-1:0]     idx     = PADDR_I[IDX_LSB +: IDX_W];
    wire                  cfg_hit = (idx == IDX_CYCLE_CFG);
    wire                  cnt_hit = (idx == IDX_COUNTER);
    wire  [CNT_W-1:0]     mask    = len_mask(len_sel);
    // the carry is seen as the tick arrives with all selected low bits at one, so the flag lands with the wrap
    wire                  cyc_ovf = COUNT_TICK_I & ((count & mask) == mask);
    wire                  cfg_wr  = wr & cfg_hit;
    wire  [BYTE_W-1:0]    cfg_rd  = {rsel, irq_en, flag, CFG_RSVD_RD, len_sel};
    wire                  next_flag = cyc_ovf | (cfg_wr ? PWDATA_I[CFG_FLAG_BIT] : flag);

    logic [NUM_CH-1:0]    hit_mode;
    logic [NUM_CH-1:0]    hit_low;
    logic [NUM_CH-1:0]    hit_high;
    logic [NUM_CH-1:0]    reload_go;
    logic [NUM_CH-1:0]    next_pwm;
    logic [DATA_W-1:0]    rd_word;

    always_comb begin
        for (int n = 0; n < NUM_CH; n++) begin
            hit_mode[n]  = reg_hit(idx, IDX_MODE_BASE, n);
            hit_low[n]   = reg_hit(idx, IDX_CMPL_BASE, n);
            hit_high[n]  = reg_hit(idx, IDX_CMPH_BASE, n);
            // reload only for 9 to 11-bit pwm, never in 8-bit or wide mode
            reload_go[n] = cyc_ovf & mode[n][MODE_PWM_BIT] & ~mode[n][MODE_WIDE_BIT]
                           & (len_sel != LEN_8BIT);
            // non-wide channels share the length mask; wide ones compare all bits
            next_pwm[n]  = mode[n][MODE_PWM_BIT] & mode[n][MODE_COMP_BIT] &
                           (mode[n][MODE_WIDE_BIT] ? (count < cmp[n])
                                                   : ((count & mask) < (cmp[n] & mask)));
        end
    end

    wire mapped = cfg_hit | cnt_hit | (|hit_mode) | (|hit_low) | (|hit_high);

    // read mux; the select bit steers compare reads between the two banks
    always_comb begin
        rd_word = RD_ZERO;
        if (cfg_hit) begin
            rd_word[BYTE_W-1:0] = cfg_rd;
        end
        if (cnt_hit) begin
            rd_word[CNT_W-1:0] = count;
        end
        for (int n = 0; n < NUM_CH; n++) begin
            if (hit_mode[n]) begin
                rd_word[BYTE_W-1:0] = mode[n];
            end
            if (hit_low[n]) begin
                rd_word[BYTE_W-1:0] = rsel ? rld[n][BYTE_W-1:0] : cmp[n][BYTE_W-1:0];
            end
            if (hit_high[n]) begin
                rd_word[BYTE_W-1:0] = rsel ? rld[n][CNT_W-1:BYTE_W] : cmp[n][CNT_W-1:BYTE_W];
            end
        end
    end

    // zero wait states; unmapped indices answer with an error, read zero and drop writes
    assign PREADY_O  = access;
    assign PSLVERR_O = access & ~mapped;
    assign IRQ_O     = flag & irq_en;
    assign PWM_O     = pwm_q;

    // read data is caught in the setup cycle so it comes from a flop yet needs no wait state
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            PRDATA_O <= RD_ZERO;
        end else if (setup & ~PWRITE_I) begin
            PRDATA_O <= rd_word;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            rsel    <= CFG_RESET[CFG_RSEL_BIT];
            irq_en  <= CFG_RESET[CFG_IRQEN_BIT];
            len_sel <= CFG_RESET[CFG_LEN_LSB +: CFG_LEN_W];
        end else if (cfg_wr) begin
            rsel    <= PWDATA_I[CFG_RSEL_BIT];
            irq_en  <= PWDATA_I[CFG_IRQEN_BIT];
            len_sel <= PWDATA_I[CFG_LEN_LSB +: CFG_LEN_W];
        end
    end

    // overflow set wins over a same-cycle software clear
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            flag <= CFG_RESET[CFG_FLAG_BIT];
        end else begin
            flag <= next_flag;
        end
    end

    // a software preset in the same cycle as a tick wins, and that tick is lost
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            count <= CNT_RESET;
        end else if (wr & cnt_hit) begin
            count <= PWDATA_I[CNT_W-1:0];
        end else if (COUNT_TICK_I) begin
            count <= count + CNT_STEP;
        end
    end

    // a software write to a compare byte takes precedence over the cycle reload
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            for (int n = 0; n < NUM_CH; n++) begin
                mode[n] <= MODE_RESET;
                cmp[n]  <= CNT_RESET;
                rld[n]  <= CNT_RESET;
                pwm_q[n] <= 1'b0;
            end
        end else begin
            for (int n = 0; n < NUM_CH; n++) begin
                pwm_q[n] <= next_pwm[n];
                if (wr & hit_mode[n]) begin
                    mode[n] <= PWDATA_I[BYTE_W-1:0];
                end
                if (wr & hit_low[n] & rsel) begin
                    rld[n][BYTE_W-1:0] <= PWDATA_I[BYTE_W-1:0];
                end
                if (wr & hit_high[n] & rsel) begin
                    rld[n][CNT_W-1:BYTE_W] <= PWDATA_I[BYTE_W-1:0];
                end
                if (wr & hit_low[n] & ~rsel) begin
                    cmp[n][BYTE_W-1:0] <= PWDATA_I[BYTE_W-1:0];
                end else if (wr & hit_high[n] & ~rsel) begin
                    cmp[n][CNT_W-1:BYTE_W] <= PWDATA_I[BYTE_W-1:0];
                end else if (reload_go[n]) begin
                    cmp[n] <= rld[n];
                end
            end
        end
    end

    irq_gate_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        IRQ_O == (flag && irq_en)) else $error("irq does not follow flag and enable");

    flag_set_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        COUNT_TICK_I && ((count & len_mask(len_sel)) == len_mask(len_sel)) |=> flag)
        else $error("cycle overflow did not set the flag");

    flag_hold_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        $fell(flag) |-> $past(cfg_wr) && !$past(PWDATA_I[CFG_FLAG_BIT]) && !$past(cyc_ovf))
        else $error("flag cleared without a software zero");

    rsvd_zero_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        PSEL_I && !PENABLE_I && !PWRITE_I && cfg_hit |=> PRDATA_O[4:2] == CFG_RSVD_RD)
        else $error("reserved configuration bits read nonzero");

    len_sel_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        cyc_ovf |-> count[BASE_LEN + int'(len_sel) - 1 -: BASE_LEN] == {BASE_LEN{1'b1}})
        else $error("overflow at the wrong cycle length");

    reload_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        reload_go[0] && !(wr && (hit_low[0] || hit_high[0])) |=> cmp[0] == $past(rld[0]))
        else $error("compare not reloaded at cycle overflow");

    no_reload_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        len_sel == LEN_8BIT && !wr |=> $stable(cmp[0]))
        else $error("reload acted in 8-bit mode");

    sel_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        setup && !PWRITE_I && hit_low[0] && rsel |=> PRDATA_O[BYTE_W-1:0] == $past(rld[0][BYTE_W-1:0]))
        else $error("select bit did not route read to reload bank");

    wide_pwm_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        mode[0][MODE_WIDE_BIT] && mode[0][MODE_PWM_BIT] && mode[0][MODE_COMP_BIT]
        |=> PWM_O[0] == ($past(count) < $past(cmp[0])))
        else $error("wide pwm channel depends on cycle length");

    // channel-level checks watch channel 0; the other channels run the same code
    flag_sw_set_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        cfg_wr && PWDATA_I[CFG_FLAG_BIT]
        |=> flag)
        else $error("software one did not set the flag");

    flag_sw_clr_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        cfg_wr && !PWDATA_I[CFG_FLAG_BIT] && !cyc_ovf
        |=> !flag)
        else $error("software zero did not clear the flag");

    flag_keep_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        flag && !cfg_wr
        |=> flag)
        else $error("flag dropped without a configuration write");

    flag_quiet_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        !flag && !cyc_ovf && !(cfg_wr && PWDATA_I[CFG_FLAG_BIT])
        |=> !flag)
        else $error("flag set without an overflow or a software one");

    len_write_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        cfg_wr
        |=> len_sel == $past(PWDATA_I[CFG_LEN_LSB +: CFG_LEN_W]))
        else $error("cycle length field not taken from the write");

    rsel_write_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        cfg_wr
        |=> rsel == $past(PWDATA_I[CFG_RSEL_BIT]))
        else $error("bank select bit not taken from the write");

    cmp_write_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        wr && hit_low[0] && !rsel
        |=> cmp[0][BYTE_W-1:0] == $past(PWDATA_I[BYTE_W-1:0]))
        else $error("compare low byte not written with select clear");

    rld_write_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        wr && hit_low[0] && rsel
        |=> rld[0][BYTE_W-1:0] == $past(PWDATA_I[BYTE_W-1:0]))
        else $error("reload low byte not written with select set");

    rld_guard_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        wr && hit_low[0] && !rsel
        |=> $stable(rld[0]))
        else $error("reload bank written with select clear");

    wide_keep_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        mode[0][MODE_WIDE_BIT] && !(wr && (hit_low[0] || hit_high[0]))
        |=> $stable(cmp[0]))
        else $error("wide channel compare reloaded");

    narrow_pwm_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        !mode[0][MODE_WIDE_BIT] && mode[0][MODE_PWM_BIT] && mode[0][MODE_COMP_BIT]
        |=> PWM_O[0] == (($past(count) & $past(mask)) < ($past(cmp[0]) & $past(mask))))
        else $error("narrow pwm channel ignores the cycle length");

    pwm_off_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        !mode[0][MODE_PWM_BIT]
        |=> !PWM_O[0])
        else $error("pwm output active with pwm mode off");

    irq_mask_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        !irq_en
        |-> !IRQ_O)
        else $error("interrupt raised while masked");

    irq_follow_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        cyc_ovf && irq_en && !cfg_wr
        |=> IRQ_O)
        else $error("enabled cycle overflow raised no interrupt");

    count_step_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        COUNT_TICK_I && !(wr && cnt_hit)
        |=> count == $past(count) + CNT_STEP)
        else $error("main counter did not advance on a tick");

    wide_len_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        mode[0][MODE_WIDE_BIT] && $stable(mode[0]) && $stable(count) && $stable(cmp[0]) && $changed(len_sel)
        |=> $stable(PWM_O[0]))
        else $error("wide pwm level moved with the cycle length");

endmodule : pcapwm_core
`default_nettype wire

/* File: common/pcapwm_pkg.sv */
// constants for the pwm cycle configuration block: register indices, field layout, reset values
// assumes a 32-bit apb with byte address = 4 * register index
package pcapwm_pkg;
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned CNT_W         = 16;
    localparam int unsigned IDX_W         = 10;
    localparam int unsigned IDX_LSB       = 2;
    // register indices (byte address is four times these)
    localparam logic [9:0]  IDX_CYCLE_CFG = 10'h0F7;
    localparam logic [9:0]  IDX_MODE_BASE = 10'h0DA;
    localparam logic [9:0]  IDX_CMPL_BASE = 10'h0E0;
    localparam logic [9:0]  IDX_CMPH_BASE = 10'h0E8;
    localparam logic [9:0]  IDX_COUNTER   = 10'h0F0;
    // pwm_cycle_config fields
    localparam int unsigned CFG_RSEL_BIT  = 7;
    localparam int unsigned CFG_IRQEN_BIT = 6;
    localparam int unsigned CFG_FLAG_BIT  = 5;
    localparam int unsigned CFG_LEN_LSB   = 0;
    localparam int unsigned CFG_LEN_W     = 2;
    localparam logic [2:0]  CFG_RSVD_RD   = 3'h0;
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    // channel_compare_mode fields
    localparam int unsigned MODE_WIDE_BIT = 7;
    localparam int unsigned MODE_COMP_BIT = 6;
    localparam int unsigned MODE_PWM_BIT  = 1;
    localparam logic [7:0]  MODE_RESET    = 8'h00;
    localparam logic [15:0] CNT_RESET     = 16'h0000;
    // cycle length: base bits plus the select value
    localparam int unsigned BASE_LEN      = 8;
    localparam logic [1:0]  LEN_8BIT      = 2'h0;
    localparam logic [31:0] LEN_ONE       = 32'h0000_0001;
    localparam logic [15:0] CNT_STEP      = 16'h0001;
    localparam logic [31:0] RD_ZERO       = 32'h0000_0000;
endpackage : pcapwm_pkg

/* File: verification/tb_top.sv */
// self-checking bench for pcapwm_core: apb registers, cycle overflow flag, reload path, pwm levels
// assumes zero-wait apb answers and a one-cycle count tick, as the design hand-over describes
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pcapwm_pkg::*;
    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    logic        psel = 1'b0;
    logic        pen  = 1'b0;
    logic        pwr  = 1'b0;
    logic        tick = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd  = 32'h0000_0000;
    logic [31:0] prd, rdv;
    logic        prdy, perr, irq, ev;
    logic [2:0]  pwm;
    logic [7:0]  v;
    logic [15:0] c0, c1, cn;
    logic [1:0]  ln;
    int          fails = 0;
    int          checks_done = 0;
    int          cyc = 0;
    always #5 mclk = ~mclk;
    pcapwm_core #(.NUM_CH(3)) dut (.MCLK_I(mclk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(padr), .PWDATA_I(pwd), .COUNT_TICK_I(tick), .PREADY_O(prdy), .PSLVERR_O(perr),
        .PRDATA_O(prd), .IRQ_O(irq), .PWM_O(pwm));
    function automatic logic [11:0] ad(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction : ad
    // narrow channels compare only the low bits of the selected cycle length
    function automatic logic pwm_exp(input logic [15:0] c, input logic [15:0] m, input logic [1:0] l,
                                     input logic wide);
        logic [15:0] k;
        k = 16'((32'h0000_0001 << (8 + l)) - 1);
        return wide ? (c < m) : ((c & k) < (m & k));
    endfunction : pwm_exp
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pen  <= 1'b0;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do begin
            @(posedge mclk);
        end while (prdy !== 1'b1);
        rdv = prd;
        ev  = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb
    task automatic tick_once();
        @(posedge mclk);
        tick <= 1'b1;
        @(posedge mclk);
        tick <= 1'b0;
    endtask : tick_once
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    // a hang in the handshake or a stuck test ends the run here
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'h1e56_7f68));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        apb(1'b0, ad(IDX_CYCLE_CFG), 32'h0000_0000);
        chk(rdv, {24'h00_0000, CFG_RESET}, "cfg reset");
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk({31'h0000_0000, ev}, 32'h0000_0001, "unmapped error");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h20 : 8'($urandom());
            apb(1'b1, ad(IDX_CYCLE_CFG), {24'h00_0000, v});
            apb(1'b0, ad(IDX_CYCLE_CFG), 32'h0000_0000);
            chk(rdv, {24'h00_0000, v & 8'hE3}, "cfg readback");
            chk(32'(irq), 32'(v[6] & v[5]), "irq level");
        end
        $display("test config done");
        for (int l = 0; l < 4; l++) begin
            apb(1'b1, ad(IDX_CYCLE_CFG), 32'h0000_0040 | l);
            apb(1'b1, ad(IDX_COUNTER), 32'h0000_00FF);
            tick_once();
            apb(1'b0, ad(IDX_CYCLE_CFG), 32'h0000_0000);
            chk(32'(rdv[5]), 32'(l == 0), "flag at 8-bit carry");
            apb(1'b1, ad(IDX_CYCLE_CFG), 32'h0000_0040 | l);
            apb(1'b1, ad(IDX_COUNTER), (32'h0000_0001 << (8 + l)) - 1);
            tick_once();
            apb(1'b0, ad(IDX_CYCLE_CFG), 32'h0000_0000);
            chk(rdv, 32'h0000_0060 | l, "flag at cycle carry");
            chk(32'(irq), 32'h0000_0001, "irq on flag");
            apb(1'b1, ad(IDX_CYCLE_CFG), 32'h0000_0040 | l);
            apb(1'b0, ad(IDX_CYCLE_CFG), 32'h0000_0000);
            chk(rdv, 32'h0000_0040 | l, "flag cleared");
        end
        $display("test flag done");
        apb(1'b1, ad(IDX_MODE_BASE), 32'h0000_0002);
        apb(1'b1, ad(10'(IDX_MODE_BASE + 1)), 32'h0000_0082);
        for (int l = 0; l < 2; l++) begin
            for (int n = 0; n < 3; n++) apb(1'b1, ad(10'(IDX_CMPL_BASE + n)), 32'h0000_0011);
            apb(1'b1, ad(IDX_CYCLE_CFG), 32'h0000_0080 | l);
            for (int n = 0; n < 3; n++) apb(1'b1, ad(10'(IDX_CMPL_BASE + n)), 32'h0000_005A);
            apb(1'b0, ad(IDX_CMPL_BASE), 32'h0000_0000);
            chk(rdv, 32'h0000_005A, "reload readback");
            apb(1'b1, ad(IDX_CYCLE_CFG), 32'h0000_0000 | l);
            apb(1'b1, ad(IDX_COUNTER), (32'h0000_0001 << (8 + l)) - 1);
            tick_once();
            for (int n = 0; n < 3; n++) begin
                apb(1'b0, ad(10'(IDX_CMPL_BASE + n)), 32'h0000_0000);
                chk(rdv, (n == 0 && l == 1) ? 32'h0000_005A : 32'h0000_0011, "compare after carry");
            end
        end
        $display("test reload done");
        for (int i = 0; i < 40; i++) begin
            c0 = (i == 0) ? 16'h0180 : 16'($urandom());
            c1 = (i == 0) ? 16'h0180 : 16'($urandom());
            cn = (i == 0) ? 16'h0090 : 16'($urandom());
            ln = (i == 0) ? 2'h0 : 2'($urandom());
            // channels 0 and 1 swap between wide and narrow pwm on alternate rounds
            apb(1'b1, ad(IDX_MODE_BASE), i[0] ? 32'h0000_00C2 : 32'h0000_0042);
            apb(1'b1, ad(10'(IDX_MODE_BASE + 1)), i[0] ? 32'h0000_0042 : 32'h0000_00C2);
            apb(1'b1, ad(IDX_CYCLE_CFG), {30'h0000_0000, ln});
            apb(1'b1, ad(IDX_CMPL_BASE), {24'h00_0000, c0[7:0]});
            apb(1'b1, ad(IDX_CMPH_BASE), {24'h00_0000, c0[15:8]});
            apb(1'b1, ad(10'(IDX_CMPL_BASE + 1)), {24'h00_0000, c1[7:0]});
            apb(1'b1, ad(10'(IDX_CMPH_BASE + 1)), {24'h00_0000, c1[15:8]});
            apb(1'b1, ad(IDX_COUNTER), {16'h0000, cn});
            repeat (2) @(posedge mclk);
            chk(32'(pwm), {29'h0000_0000, 1'b0, pwm_exp(cn, c1, ln, ~i[0]), pwm_exp(cn, c0, ln, i[0])}, "pwm");
            apb(1'b0, ad(IDX_COUNTER), 32'h0000_0000);
            chk(rdv, {16'h0000, cn}, "counter readback");
            apb(1'b0, ad(IDX_CMPH_BASE), 32'h0000_0000);
            chk(rdv, {24'h00_0000, c0[15:8]}, "compare high readback");
        end
        $display("test pwm done");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
